/* pss_pkg.sv */
// proximity status/result register bank: shared constants and types
// assumes a 250 MHz core clock and a two-wire serial link on its own clock
package pss_pkg;
  localparam int   CLK_FREQ_MHZ   = 250;
  localparam real  WAIT_INC_MS    = 2.78;
  localparam int   WAIT_INC_CYC   = int'($floor(WAIT_INC_MS * 1.0e3 * CLK_FREQ_MHZ));
  localparam int   LONG_WAIT_MULT = 12;
  localparam int   APC_SCALE      = 16;

  localparam logic [7:0] ADDR_MODE    = 8'h80;
  localparam logic [7:0] ADDR_CONFIG_REG_ZERO    = 8'h81;
  localparam logic [7:0] ADDR_THR_LO  = 8'h88;
  localparam logic [7:0] ADDR_THR_HI  = 8'h8a;
  localparam logic [7:0] ADDR_ID      = 8'h92;
  localparam logic [7:0] ADDR_STATUS  = 8'h9b;
  localparam logic [7:0] ADDR_RES_LO  = 8'h9c;
  localparam logic [7:0] ADDR_RES_HI  = 8'h9d;
  localparam logic [7:0] ADDR_VER     = 8'ha6;
  localparam logic [7:0] ADDR_SOFT_RESET_BIT = 8'ha8;
  localparam logic [7:0] ADDR_WAIT    = 8'ha9;
  localparam logic [7:0] ADDR_CONFIG_REG_THREE    = 8'hab;
  localparam logic [7:0] ADDR_CONFIG_REG_SIX    = 8'hae;

  localparam int ST_HIGH = 7;
  localparam int ST_LOW  = 6;
  localparam int ST_SAT  = 5;
  localparam int ST_PROX_IRQ_FLAG = 4;
  localparam int ST_CAL  = 3;
  localparam int ST_ZERO = 2;
  localparam int ST_REFL = 1;
  localparam int ST_AMB  = 0;
  localparam int MODE_PON     = 0;
  localparam int MODE_PROX_IRQ_ENABLE    = 1;
  localparam int MODE_AUTOOFS = 2;
  localparam int CONFIG_REG_ZERO_LONG    = 3;
  localparam int CONFIG_REG_THREE_RDCLR   = 7;
  localparam int CONFIG_REG_THREE_SAI     = 4;
  localparam int CONFIG_REG_SIX_APC_OFF = 6;
  localparam int SOFT_RESET_BIT_BIT  = 0;

  localparam logic [7:0] CONFIG_REG_THREE_RST = 8'h04;
  localparam logic [7:0] CONFIG_REG_SIX_RST = 8'h3f;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  config_reg_zero;
    logic [7:0]  thr_lo;
    logic [7:0]  thr_hi;
    logic [7:0]  wait_period;
    logic [7:0]  config_reg_three;
    logic [7:0]  config_reg_six;
    logic [7:0]  status;
    logic [7:0]  hi_shadow;
    logic [13:0] result;
    logic        res_apc_off;
    logic        sat_seen;
    logic [3:0]  persist;
    logic        waiting;
    logic [7:0]  wait_cnt;
    logic [3:0]  wait_sub;
    logic [23:0] tick;
    logic        wait_done;
    logic        osc_run;
    logic        soft_rst;
  } pss_regs_s;

  localparam pss_regs_s REGS_RST = '{config_reg_three: CONFIG_REG_THREE_RST, config_reg_six: CONFIG_REG_SIX_RST, default: '0};

  typedef struct packed {
    logic       valid;
    logic [9:0] adc;
    logic [6:0] pulses;
  } pss_sample_s;

  typedef struct packed {
    logic calib_done;
    logic zero_dec;
    logic reflect_sat;
    logic ambient_sat;
    logic wait_start;
  } pss_evt_s;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pss_req_s;

  typedef enum logic [8:0] {
    L_IDLE = 9'h001,
    L_ADDR = 9'h002,
    L_AACK = 9'h004,
    L_REG  = 9'h008,
    L_RACK = 9'h010,
    L_WDAT = 9'h020,
    L_WACK = 9'h040,
    L_RDAT = 9'h080,
    L_MACK = 9'h100
  } pss_lstate_e;

  typedef struct packed {
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic [2:0]  ack_sy;
    pss_lstate_e state;
    logic [2:0]  cnt;
    logic [7:0]  sh;
    logic        drv;
    logic        is_read;
    logic [7:0]  ptr;
    logic        req_tgl;
    pss_req_s    req;
    logic        sda_oe;
    logic        sda_o;
  } pss_link_s;

  typedef struct packed {
    logic [2:0] req_sy;
    logic       ack_tgl;
    logic [7:0] rdata;
    pss_regs_s  r;
  } pss_core_s;
endpackage

/* pss_regs.sv */
// proximity status/result register bank with its serial-bus slave front end
// assumes sample and event inputs are synchronous to i_clk, bus pins are asynchronous
`timescale 1ns/10ps
// Behaviour
// - above_high_flag sets with prox_irq_flag when above high; clears with it.
// - below_low_flag sets with prox_irq_flag when below low; clears with it.
// - any_saturation_flag sets if any saturation hit the finished cycle.
// - prox_irq_flag sets once threshold crossing meets persistence.
// - calib_done_flag sets when calibration completes.
// - zero_detect_flag sets on zero-driven offset decrement with auto_offset_tune on.
// - reflect_sat_flag sets on saturation while emitter active.
// - ambient_sat_flag sets on saturation while emitter inactive.
// - writing one to a status bit clears it.
// - with read-clear on, a status read clears all eight flags.
// - low-byte read latches high byte; host reads low byte first.
// - with auto_pulse_ctrl on, result is adc times 16 over pulses.
// - with auto_pulse_ctrl off, low byte holds bits 9:2, high bits 1:0.
// - with auto_pulse_ctrl off, upper 8 result bits meet thresholds.
// - soft_reset_bit restores all defaults, stops work, enters sleep.
// - wait timer counts down field plus one increments of 2.78ms.
// - long_wait_en multiplies each wait increment by 12.
// - read-clear enable sits at bit 7 of config_reg_three.
// - bit 6 of config_reg_six set disables auto_pulse_ctrl.
// - sleep_after_irq with irq and enable stops oscillator; power_on reads one.
module pss_regs #(
  parameter logic [6:0] DEV_ADDR      = 7'h2a,
  parameter logic [5:0] ID_CODE       = 6'h2d, // arbitrary value
  parameter logic [3:0] VER_CODE      = 4'h5,  // arbitrary value
  parameter int         PERSIST_N     = 1,
  parameter int         WAIT_TICK_CYC = pss_pkg::WAIT_INC_CYC
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_link_clk,
  input  wire logic                 i_link_rst_b,
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  output logic                      o_sda_o,
  output logic                      o_sda_oe,
  input  wire pss_pkg::pss_sample_s i_sample,
  input  wire pss_pkg::pss_evt_s    i_evt,
  output logic                      o_osc_run,
  output logic                      o_wait_done,
  output logic                      o_soft_rst
);
  pss_pkg::pss_core_s cq, cd;
  pss_pkg::pss_link_s lq, ld;
  pss_pkg::pss_req_s  req;
  logic               acc, acc_rd, acc_wr;
  logic [7:0]         rval, lo_val, hi_val, set_v, clr_v, cmp;
  logic [6:0]         div;
  logic [13:0]        res_new;
  logic               apc_off, above, below, prox_irq_flag_ev;
  logic               rise, fall, sda, start, stop;
  logic [7:0]         byte_in;

  // core domain: register file, flags, result formatting, wait timer
  always_comb begin
    cd       = cq;
    req      = lq.req; // held stable by the link until the ack toggle returns
    cd.req_sy = {cq.req_sy[1:0], lq.req_tgl};
    acc      = cq.req_sy[2] ^ cq.req_sy[1];
    acc_rd   = acc & ~req.we;
    acc_wr   = acc & req.we;
    apc_off  = cq.r.config_reg_six[pss_pkg::CONFIG_REG_SIX_APC_OFF];
    lo_val   = cq.r.res_apc_off ? cq.r.result[9:2] : cq.r.result[7:0];
    hi_val   = cq.r.res_apc_off ? {6'h00, cq.r.result[1:0]} : {2'h0, cq.r.result[13:8]};
    case (req.addr)
      pss_pkg::ADDR_MODE:   rval = cq.r.mode;
      pss_pkg::ADDR_CONFIG_REG_ZERO:   rval = cq.r.config_reg_zero;
      pss_pkg::ADDR_THR_LO: rval = cq.r.thr_lo;
      pss_pkg::ADDR_THR_HI: rval = cq.r.thr_hi;
      pss_pkg::ADDR_ID:     rval = {ID_CODE, 2'b00};
      pss_pkg::ADDR_STATUS: rval = cq.r.status;
      pss_pkg::ADDR_RES_LO: rval = lo_val;
      pss_pkg::ADDR_RES_HI: rval = cq.r.hi_shadow;
      pss_pkg::ADDR_VER:    rval = {4'h0, VER_CODE};
      pss_pkg::ADDR_WAIT:   rval = cq.r.wait_period;
      pss_pkg::ADDR_CONFIG_REG_THREE:   rval = cq.r.config_reg_three;
      pss_pkg::ADDR_CONFIG_REG_SIX:   rval = cq.r.config_reg_six;
      default:              rval = 8'h00;
    endcase
    if (acc) begin
      cd.rdata   = rval;
      cd.ack_tgl = ~cq.ack_tgl;
    end
    // zero pulse count cannot happen in a real cycle; guarded against divide by zero
    div     = (i_sample.pulses == 7'h00) ? 7'h01 : i_sample.pulses;
    res_new = apc_off ? {4'h0, i_sample.adc}
                      : ({i_sample.adc, 4'h0} / {7'h00, div});
    cmp     = apc_off ? res_new[9:2] : res_new[13:6];
    above   = cmp > cq.r.thr_hi;
    below   = cmp < cq.r.thr_lo;
    prox_irq_flag_ev = i_sample.valid & (above | below)
              & (5'({1'b0, cq.r.persist}) + 5'h01 >= 5'(PERSIST_N));
    set_v                  = 8'h00;
    set_v[pss_pkg::ST_PROX_IRQ_FLAG] = prox_irq_flag_ev;
    set_v[pss_pkg::ST_HIGH] = prox_irq_flag_ev & above;
    set_v[pss_pkg::ST_LOW]  = prox_irq_flag_ev & below;
    set_v[pss_pkg::ST_SAT]  = i_sample.valid & (cq.r.sat_seen | i_evt.reflect_sat
                              | i_evt.ambient_sat);
    set_v[pss_pkg::ST_CAL]  = i_evt.calib_done;
    set_v[pss_pkg::ST_ZERO] = i_evt.zero_dec & cq.r.mode[pss_pkg::MODE_AUTOOFS];
    set_v[pss_pkg::ST_REFL] = i_evt.reflect_sat;
    set_v[pss_pkg::ST_AMB]  = i_evt.ambient_sat;
    clr_v = 8'h00;
    if (acc_wr && req.addr == pss_pkg::ADDR_STATUS) begin
      clr_v = req.wdata;
    end
    if (acc_rd && req.addr == pss_pkg::ADDR_STATUS && cq.r.config_reg_three[pss_pkg::CONFIG_REG_THREE_RDCLR]) begin
      clr_v = 8'hff;
    end
    if (clr_v[pss_pkg::ST_PROX_IRQ_FLAG]) begin
      clr_v[pss_pkg::ST_HIGH] = 1'b1;
      clr_v[pss_pkg::ST_LOW]  = 1'b1;
    end
    // a new event in the clearing cycle survives the clear
    cd.r.status = (cq.r.status & ~clr_v) | set_v;
    if (i_evt.reflect_sat | i_evt.ambient_sat) begin
      cd.r.sat_seen = 1'b1;
    end
    if (i_sample.valid) begin
      cd.r.result      = res_new;
      cd.r.res_apc_off = apc_off;
      cd.r.sat_seen    = 1'b0;
      if (!(above | below)) begin
        cd.r.persist = 4'h0;
      end else if (cq.r.persist != 4'hf) begin
        cd.r.persist = cq.r.persist + 4'h1;
      end
    end
    if (acc_rd && req.addr == pss_pkg::ADDR_RES_LO) begin
      cd.r.hi_shadow = hi_val;
    end
    if (acc_wr) begin
      case (req.addr)
        pss_pkg::ADDR_MODE:   cd.r.mode        = req.wdata;
        pss_pkg::ADDR_CONFIG_REG_ZERO:   cd.r.config_reg_zero        = req.wdata;
        pss_pkg::ADDR_THR_LO: cd.r.thr_lo      = req.wdata;
        pss_pkg::ADDR_THR_HI: cd.r.thr_hi      = req.wdata;
        pss_pkg::ADDR_WAIT:   cd.r.wait_period = req.wdata;
        pss_pkg::ADDR_CONFIG_REG_THREE:   cd.r.config_reg_three        = req.wdata;
        pss_pkg::ADDR_CONFIG_REG_SIX:   cd.r.config_reg_six        = req.wdata;
        default:              cd.r.config_reg_zero        = cq.r.config_reg_zero;
      endcase
    end
    cd.r.wait_done = 1'b0;
    if (i_evt.wait_start) begin
      cd.r.waiting  = 1'b1;
      cd.r.wait_cnt = cq.r.wait_period;
      cd.r.wait_sub = cq.r.config_reg_zero[pss_pkg::CONFIG_REG_ZERO_LONG]
                      ? 4'(pss_pkg::LONG_WAIT_MULT - 1) : 4'h0;
      cd.r.tick     = 24'(WAIT_TICK_CYC - 1);
    end else if (cq.r.waiting && cq.r.osc_run) begin
      if (cq.r.tick != 24'h000000) begin
        cd.r.tick = cq.r.tick - 24'h000001;
      end else begin
        cd.r.tick = 24'(WAIT_TICK_CYC - 1);
        if (cq.r.wait_sub != 4'h0) begin
          cd.r.wait_sub = cq.r.wait_sub - 4'h1;
        end else if (cq.r.wait_cnt != 8'h00) begin
          cd.r.wait_cnt = cq.r.wait_cnt - 8'h01;
          cd.r.wait_sub = cq.r.config_reg_zero[pss_pkg::CONFIG_REG_ZERO_LONG]
                          ? 4'(pss_pkg::LONG_WAIT_MULT - 1) : 4'h0;
        end else begin
          cd.r.waiting   = 1'b0;
          cd.r.wait_done = 1'b1;
        end
      end
    end
    // the mode register keeps power_on set while the oscillator is parked
    cd.r.osc_run = cd.r.mode[pss_pkg::MODE_PON] & ~(cd.r.config_reg_three[pss_pkg::CONFIG_REG_THREE_SAI]
                   & cd.r.status[pss_pkg::ST_PROX_IRQ_FLAG] & cd.r.mode[pss_pkg::MODE_PROX_IRQ_ENABLE]);
    cd.r.soft_rst = 1'b0;
    if (acc_wr && req.addr == pss_pkg::ADDR_SOFT_RESET_BIT && req.wdata[pss_pkg::SOFT_RESET_BIT_BIT]) begin
      cd.r          = pss_pkg::REGS_RST;
      cd.r.soft_rst = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cq <= '{r: pss_pkg::REGS_RST, default: '0};
    end else begin
      cq <= cd;
    end
  end

  // link domain: oversampled serial slave, one request in flight at a time
  always_comb begin
    ld        = lq;
    ld.scl_sy = {lq.scl_sy[1:0], i_scl};
    ld.sda_sy = {lq.sda_sy[1:0], i_sda};
    ld.ack_sy = {lq.ack_sy[1:0], cq.ack_tgl};
    rise      = lq.scl_sy[1] & ~lq.scl_sy[2];
    fall      = ~lq.scl_sy[1] & lq.scl_sy[2];
    sda       = lq.sda_sy[1];
    start     = lq.scl_sy[1] & lq.scl_sy[2] & lq.sda_sy[2] & ~sda;
    stop      = lq.scl_sy[1] & lq.scl_sy[2] & ~lq.sda_sy[2] & sda;
    byte_in   = {lq.sh[6:0], sda};
    if (start) begin
      ld.state  = pss_pkg::L_ADDR;
      ld.cnt    = 3'h0;
      ld.sda_oe = 1'b0;
      ld.drv    = 1'b0;
    end else if (stop) begin
      ld.state  = pss_pkg::L_IDLE;
      ld.sda_oe = 1'b0;
    end else begin
      case (lq.state)
        pss_pkg::L_IDLE: ld.state = pss_pkg::L_IDLE;
        pss_pkg::L_ADDR, pss_pkg::L_REG, pss_pkg::L_WDAT: begin
          if (rise) begin
            ld.sh  = byte_in;
            ld.cnt = lq.cnt + 3'h1;
            if (lq.cnt == 3'h7) begin
              if (lq.state == pss_pkg::L_REG) begin
                ld.ptr   = byte_in;
                ld.state = pss_pkg::L_RACK;
              end else if (lq.state == pss_pkg::L_WDAT) begin
                ld.req     = '{we: 1'b1, addr: lq.ptr, wdata: byte_in};
                ld.req_tgl = ~lq.req_tgl;
                ld.ptr     = lq.ptr + 8'h01;
                ld.state   = pss_pkg::L_WACK;
              end else if (byte_in[7:1] == DEV_ADDR) begin
                ld.is_read = byte_in[0];
                ld.state   = pss_pkg::L_AACK;
                if (byte_in[0]) begin
                  ld.req     = '{we: 1'b0, addr: lq.ptr, wdata: 8'h00};
                  ld.req_tgl = ~lq.req_tgl;
                  ld.ptr     = lq.ptr + 8'h01;
                end
              end else begin
                ld.state = pss_pkg::L_IDLE;
              end
            end
          end
        end
        pss_pkg::L_AACK, pss_pkg::L_RACK, pss_pkg::L_WACK: begin
          if (fall && !lq.drv) begin
            ld.sda_oe = 1'b1;
            ld.drv    = 1'b1;
          end else if (fall) begin
            ld.sda_oe = 1'b0;
            ld.drv    = 1'b0;
            ld.cnt    = 3'h0;
            ld.state  = pss_pkg::L_WDAT;
            if (lq.state == pss_pkg::L_AACK && lq.is_read) begin
              ld.state  = pss_pkg::L_RDAT;
              ld.sh     = cq.rdata; // stable: the core answered during the ack bit
              ld.sda_oe = ~cq.rdata[7];
            end else if (lq.state == pss_pkg::L_AACK) begin
              ld.state = pss_pkg::L_REG;
            end
          end
        end
        pss_pkg::L_RDAT: begin
          if (fall && lq.cnt == 3'h7) begin
            ld.sda_oe = 1'b0;
            ld.cnt    = 3'h0;
            ld.state  = pss_pkg::L_MACK;
          end else if (fall) begin
            ld.cnt    = lq.cnt + 3'h1;
            ld.sh     = {lq.sh[6:0], 1'b0};
            ld.sda_oe = ~lq.sh[6];
          end
        end
        pss_pkg::L_MACK: begin
          if (rise && !sda) begin
            ld.req     = '{we: 1'b0, addr: lq.ptr, wdata: 8'h00};
            ld.req_tgl = ~lq.req_tgl;
            ld.ptr     = lq.ptr + 8'h01;
            ld.drv     = 1'b1;
          end else if (rise) begin
            ld.state = pss_pkg::L_IDLE;
          end else if (fall && lq.drv) begin
            ld.drv    = 1'b0;
            ld.state  = pss_pkg::L_RDAT;
            ld.sh     = cq.rdata;
            ld.sda_oe = ~cq.rdata[7];
          end
        end
        default: ld.state = pss_pkg::L_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!i_link_rst_b) begin
      lq <= '{state: pss_pkg::L_IDLE, default: '0};
    end else begin
      lq <= ld;
    end
  end

  assign o_sda_o     = lq.sda_o;
  assign o_sda_oe    = lq.sda_oe;
  assign o_osc_run   = cq.r.osc_run;
  assign o_wait_done = cq.r.wait_done;
  assign o_soft_rst  = cq.r.soft_rst;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  hl_needs_prox_irq_flag_a: assert property ((cq.r.status[7] | cq.r.status[6]) |-> cq.r.status[4])
    else $error("high or low flag without interrupt flag");
  prox_irq_flag_set_a: assert property (prox_irq_flag_ev & !cq.r.soft_rst |=> cq.r.status[4] | cq.r.soft_rst)
    else $error("interrupt flag missed its event");
  sat_comb_a: assert property (
    i_sample.valid & (i_evt.reflect_sat | cq.r.sat_seen) & !acc |=> cq.r.status[5])
    else $error("combined saturation flag not set");
  w1c_a: assert property (
    acc_wr && req.addr == pss_pkg::ADDR_STATUS && set_v == 8'h00
    |=> (cq.r.status & $past(req.wdata)) == 8'h00)
    else $error("written one did not clear flag");
  // a same-cycle event may legally set a bit that was zero, so only quiet cycles are judged
  w0_keep_a: assert property (
    acc_wr && req.addr == pss_pkg::ADDR_STATUS && !req.wdata[4] && set_v == 8'h00
    |=> (cq.r.status & ~$past(req.wdata)) == ($past(cq.r.status) & ~$past(req.wdata)))
    else $error("zero write disturbed a flag");
  rd_clear_a: assert property (
    acc_rd && req.addr == pss_pkg::ADDR_STATUS
    && cq.r.config_reg_three[7] && set_v == 8'h00 |=> cq.r.status == 8'h00)
    else $error("read-clear left flags set");
  hi_latch_a: assert property (
    acc_rd && req.addr == pss_pkg::ADDR_RES_LO && !i_sample.valid
    |=> cq.r.hi_shadow == $past(hi_val) && $stable(cq.r.result))
    else $error("high byte not latched on low read");
  apc_unity_a: assert property (
    i_sample.valid && !apc_off && i_sample.pulses == 7'd16
    && !acc |=> cq.r.result == {4'h0, $past(i_sample.adc)})
    else $error("scaled result wrong at sixteen pulses");
  raw_fmt_a: assert property (
    i_sample.valid && apc_off && !acc
    |=> lo_val == $past(i_sample.adc[9:2]) && hi_val == {6'h00, $past(i_sample.adc[1:0])})
    else $error("raw result packed wrongly");
  soft_rst_a: assert property (
    acc_wr && req.addr == pss_pkg::ADDR_SOFT_RESET_BIT && req.wdata[0]
    |=> !cq.r.osc_run && cq.r.status == 8'h00 && cq.r.config_reg_three == 8'h04 ##1 !cq.r.soft_rst)
    else $error("soft reset did not restore defaults");
  long_load_a: assert property (
    i_evt.wait_start && cq.r.config_reg_zero[3] && !acc
    |=> cq.r.wait_sub == 4'd11 && cq.r.waiting)
    else $error("long wait multiplier not loaded");
  cnt_step_a: assert property (
    cq.r.waiting && cq.r.osc_run && cq.r.tick == 24'h0
    && cq.r.wait_sub == 4'h0 && cq.r.wait_cnt != 8'h0 && !i_evt.wait_start
    |=> cq.r.wait_cnt == $past(cq.r.wait_cnt) - 8'h01)
    else $error("wait counter missed a step");
  sai_stop_a: assert property (
    cq.r.config_reg_three[4] && cq.r.status[4] && cq.r.mode[1]
    && cq.r.mode[0] |-> !o_osc_run)
    else $error("oscillator ran after interrupt in sleep-after mode");

  rdclr_c: cover property (acc_rd && req.addr == pss_pkg::ADDR_STATUS && cq.r.config_reg_three[7]);
  soft_reset_bit_c: cover property (o_soft_rst);
  waitdone_c: cover property (o_wait_done);
  sai_c: cover property (cq.r.mode[0] && !o_osc_run);
  linkread_c: cover property (@(posedge i_link_clk) lq.state == pss_pkg::L_MACK);
endmodule

/* pss_host.sv */
// two-wire bus host model: bit-banged master that only pulls the data line low
// assumes the bench resolves the wire with a pull-up
`timescale 1ns/10ps
module pss_host #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  int nacks;
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
    nacks     = 0;
  end
  // 80 ns phases leave the device its sync and answer slack
  task automatic bit_io(input logic b, output logic s);
    o_sda_low = ~b;
    #40 o_scl = 1'b1;
    #40 s = i_sda;
    #40 o_scl = 1'b0;
    #40;
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda_low = 1'b1;
    #80 o_scl = 1'b0;
    #40;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    #40 o_scl = 1'b1;
    #40 o_sda_low = 1'b0;
    #80;
  endtask
  task automatic put(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    if (s !== 1'b0) begin
      nacks++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    put({ADDR, 1'b0});
    put(a);
    put(d);
    stop();
  endtask
  // single-byte read ends with a nack so no further byte is fetched
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic s;
    start();
    put({ADDR, 1'b0});
    put(a);
    start();
    put({ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, s);
    stop();
  endtask
endmodule

/* tb.sv */
// bench for the proximity status/result bank, driven over the serial bus
// assumes the shortened wait tick of 4 core cycles
`timescale 1ns/10ps
module tb;
  logic                clk = 1'b0;
  logic                lclk = 1'b0;
  logic                rst_b = 1'b0;
  logic                scl;
  logic                host_low;
  logic                sda_oe;
  logic                sda_o;
  logic                osc;
  logic                wdone;
  logic                srst;
  logic [7:0]          srst_n = 8'h00;
  pss_pkg::pss_sample_s smp;
  pss_pkg::pss_evt_s   evt;
  int                  errors = 0;
  int                  samples_checked = 0;
  wire                 sda = ~(sda_oe | host_low);

  always #2 clk = ~clk;
  always #3 lclk = ~lclk;
  always @(posedge clk) if (srst === 1'b1) srst_n <= srst_n + 8'h01;

  pss_regs #(.WAIT_TICK_CYC(4)) dut (.i_clk(clk), .i_rst_b(rst_b), .i_link_clk(lclk),
    .i_link_rst_b(rst_b), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_sample(smp), .i_evt(evt), .o_osc_run(osc), .o_wait_done(wdone), .o_soft_rst(srst));
  pss_host host (.i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask
  task automatic fire(input pss_pkg::pss_sample_s s, input pss_pkg::pss_evt_s e);
    @(negedge clk);
    smp = s;
    evt = e;
    @(negedge clk);
    smp = '0;
    evt = '0;
  endtask
  task automatic wait_chk(input int lo, input int hi);
    int n;
    n = 0;
    fire('0, 5'h01);
    while (wdone !== 1'b1 && n < 1400) begin
      @(negedge clk);
      n++;
    end
    check(8'(n >= lo && n <= hi), 8'h01);
  endtask
  task automatic stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #350000;
    errors++;
    stop_test();
  end

  initial begin
    smp = '0;
    evt = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    #100;
    rd(8'h92, 8'hb4);
    rd(8'ha6, 8'h05);
    rd(8'hab, 8'h04);
    rd(8'hae, 8'h3f);
    rd(8'ha7, 8'h00);
    host.wr(8'h92, 8'hff);
    rd(8'h92, 8'hb4);
    host.wr(8'h80, 8'h05);
    host.wr(8'h88, 8'h10);
    host.wr(8'h8a, 8'h80);
    fire('0, 5'h1e);
    fire('{1'b1, 10'h3ff, 7'd1}, '0);
    rd(8'h9b, 8'hbf);
    rd(8'h9c, 8'hf0);
    // a later sample must not disturb the latched high byte
    fire('{1'b1, 10'h001, 7'd1}, '0);
    rd(8'h9d, 8'h3f);
    rd(8'h9b, 8'hff);
    host.wr(8'h9b, 8'h00);
    rd(8'h9b, 8'hff);
    host.wr(8'h9b, 8'h10);
    rd(8'h9b, 8'h2f);
    host.wr(8'h9b, 8'h0f);
    rd(8'h9b, 8'h20);
    host.wr(8'hab, 8'h84);
    rd(8'h9b, 8'h20);
    rd(8'h9b, 8'h00);
    host.wr(8'hae, 8'h7f);
    fire('{1'b1, 10'h2c5, 7'd4}, '0);
    rd(8'h9c, 8'hb1);
    rd(8'h9d, 8'h01);
    rd(8'h9b, 8'h90);
    fire('{1'b1, 10'h03c, 7'd4}, '0);
    rd(8'h9b, 8'h50);
    host.wr(8'hab, 8'h94);
    host.wr(8'h80, 8'h07);
    check(8'(osc), 8'h01);
    fire('{1'b1, 10'h3ff, 7'd4}, '0);
    repeat (4) @(negedge clk);
    check(8'(osc), 8'h00);
    rd(8'h80, 8'h07);
    rd(8'h9b, 8'h90);
    repeat (4) @(negedge clk);
    check(8'(osc), 8'h01);
    host.wr(8'ha9, 8'h01);
    rd(8'ha9, 8'h01);
    wait_chk(7, 11);
    host.wr(8'h81, 8'h08);
    wait_chk(95, 121);
    host.wr(8'h81, 8'h00);
    host.wr(8'ha9, 8'hff);
    wait_chk(1023, 1281);
    host.wr(8'ha8, 8'h01);
    check(srst_n, 8'h01);
    check(8'(osc), 8'h00);
    rd(8'ha9, 8'h00);
    rd(8'hab, 8'h04);
    rd(8'h80, 8'h00);
    rd(8'ha8, 8'h00);
    check(8'(host.nacks), 8'h00);
    stop_test();
  end
endmodule
